// ### verilog/osd_consts.svh
// Purpose: constants of the oscillator start-up delay control
// Assumes: 40 MHz clk, Avalon-MM byte addresses, 32-bit data
// Notes: included by the controller module and the testbench
//
// Notes on behaviour
// RULE1: crystal modes count 1024 oscillator input edges
// RULE2: execution held while start-up count runs
// RULE3: low-gain shared-oscillator sleep wake skips the count
// RULE4: watchdog held in reset during the count
// RULE5: internal, clock-input, resistor-capacitor wakes get 10 us delay
// RULE6: switch to crystal mode runs full count
// RULE7: switch to clock-input or resistor-capacitor adds 10 us
// RULE8: external clock mode never runs the count
// RULE9: fully static logic, stopped clock keeps state
// RULE10: external clock mode frees port A bit 6
// RULE11: mode selects amplifier gain low, medium, high
// RULE12: low-gain oscillator shared, runs in sleep if enabled
// RULE13: trim changes settle gradually, software must wait
// RULE14: mode codes low 000, medium 001, high 010
// RULE15: external clock flag 1 external, 0 internal
// RULE16: fixed delay timed by low-frequency oscillator counter; code counts 400 clk cycles plus one low-frequency edge
`ifndef OSD_CONSTS_SVH
`define OSD_CONSTS_SVH

`define OSD_ADDR_CTRL       4'h0
`define OSD_ADDR_TRIM       4'h4
`define OSD_ADDR_STATUS     4'h8

`define OSD_MODE_LOWG       3'h0
`define OSD_MODE_MEDG       3'h1
`define OSD_MODE_HIGHG      3'h2
`define OSD_MODE_EXTC       3'h3
`define OSD_MODE_RCAP       3'h4
`define OSD_MODE_RCAP_IO    3'h5
`define OSD_MODE_INT        3'h6
`define OSD_MODE_INTIO      3'h7

`define OSD_CTRL_MODE_LSB   0
`define OSD_CTRL_MODE_MSB   2
`define OSD_CTRL_SECEN_BIT  4
`define OSD_CTRL_CSEL_BIT   5
`define OSD_CTRL_WDTEN_BIT  6
`define OSD_CTRL_SLEEP_BIT  7
`define OSD_STAT_EXT_BIT    0
`define OSD_STAT_HOLD_BIT   1
`define OSD_STAT_WDTH_BIT   2
`define OSD_TRIM_MSB        4

`define OSD_MODE_RST        3'h0
`define OSD_TRIM_RST        5'h00

`define OSD_CLK_PERIOD_NS   25
`define OSD_FIXED_DELAY_NS  10000
`define OSD_FIXED_DELAY_CYC ((`OSD_FIXED_DELAY_NS + `OSD_CLK_PERIOD_NS - 1) / `OSD_CLK_PERIOD_NS)
`define OSD_XTAL_EDGES      1024
`define OSD_LF_EDGES        1

`endif

// ### verilog/osd_pkg.sv
// Purpose: types of the oscillator start-up delay control
// Assumes: constants come from osd_consts.svh
// Notes: carriers for the bus and the block state
package osd_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } osd_avm_req_t;

    typedef enum logic [1:0] {
        OSD_GAIN_OFF,
        OSD_GAIN_LOW,
        OSD_GAIN_MED,
        OSD_GAIN_HIGH
    } osd_gain_t;

    typedef enum logic [2:0] {
        OSD_ST_PWRUP,
        OSD_ST_XTAL,
        OSD_ST_DELAY,
        OSD_ST_RUN,
        OSD_ST_SLEEP
    } osd_state_t;

    typedef struct packed {
        logic       wdt_en;
        logic       clk_sel;
        logic       sec_en;
        logic [2:0] mode;
    } osd_ctrl_t;

endpackage

// ### verilog/osd_edge_counter.sv
// Purpose: counts tick pulses up to a terminal value
// Assumes: tick is a one-cycle pulse in clk
// Notes: done stays high until clear
`timescale 1ns/10ps
module osd_edge_counter #(
    parameter int WIDTH    = 11,
    parameter int TERMINAL = 1024
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic tick,
    output logic      done
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             done;
    } osd_cnt_state_t;

    osd_cnt_state_t st_reg;
    osd_cnt_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (clear) begin
            st_next.count = '0;
            st_next.done  = 1'b0;
        end else if (tick && !st_reg.done) begin
            st_next.count = st_reg.count + WIDTH'(1);
            if (st_reg.count == WIDTH'(TERMINAL - 1)) begin
                st_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;

endmodule

// ### verilog/osd_startup_ctrl.sv
// Purpose: start-up delay control of the system oscillator
// Assumes: pins synchronous to clk; Avalon-MM slave with waitrequest
// Notes: oscillator and low-frequency inputs are sampled levels
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`include "osd_consts.svh"
module osd_startup_ctrl (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire osd_pkg::osd_avm_req_t avm_req,
    output logic [31:0]               avm_readdata,
    output logic                      avm_waitrequest,
    input  wire logic                 oscillator_input_pin,
    input  wire logic                 low_freq_internal_osc,
    input  wire logic                 power_up_delay_timer_enable,
    input  wire logic                 power_up_delay_timer_expired,
    input  wire logic                 wake_event,
    output logic                      cpu_hold,
    output logic                      watchdog_counter_reset,
    output logic                      watchdog_counter_run,
    output logic [1:0]                amp_gain,
    output logic                      port_a_bit6_pin_gpio,
    output logic                      shared_osc_run_in_sleep,
    output logic                      external_clock_active_flag,
    output logic [4:0]                trim_value
);

    ////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops

    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // block state

    typedef struct packed {
        osd_pkg::osd_state_t state;
        osd_pkg::osd_ctrl_t  ctrl;
        logic [4:0]          trim;
        logic                ext_flag;
        logic                osc_prev;
        logic                lf_prev;
        logic                waitrequest;
        logic [31:0]         readdata;
        logic                cpu_hold;
        logic                wdt_reset;
        logic                wdt_run;
        osd_pkg::osd_gain_t  gain;
        logic                pa6_gpio;
        logic                osc_sleep_run;
    } osd_state_reg_t;

    osd_state_reg_t st_reg;
    osd_state_reg_t st_next;

    logic xtal_done;
    logic dly_done;
    logic lf_done;
    logic osc_rise;
    logic lf_rise;
    logic cnt_xtal_clear;
    logic cnt_dly_clear;

    assign osc_rise       = oscillator_input_pin && !st_reg.osc_prev;
    assign lf_rise        = low_freq_internal_osc && !st_reg.lf_prev;
    assign cnt_xtal_clear = st_reg.state != osd_pkg::OSD_ST_XTAL;
    assign cnt_dly_clear  = st_reg.state != osd_pkg::OSD_ST_DELAY;

    ////////////////////////////////////////////////////////////////////
    // start-up counters

    // crystal start-up count of oscillator input edges
    osd_edge_counter #(.WIDTH(11), .TERMINAL(`OSD_XTAL_EDGES)) u_xtal_cnt ( // RULE1
        .clk   (clk),
        .rst_n (rst_n),
        .clear (cnt_xtal_clear),
        .tick  (osc_rise),
        .done  (xtal_done)
    );

    // fixed delay in system clock cycles
    osd_edge_counter #(.WIDTH(9), .TERMINAL(`OSD_FIXED_DELAY_CYC)) u_dly_cnt ( // RULE5
        .clk   (clk),
        .rst_n (rst_n),
        .clear (cnt_dly_clear),
        .tick  (1'b1),
        .done  (dly_done)
    );

    // one rising edge of the low-frequency input must also arrive before the fixed delay ends
    osd_edge_counter #(.WIDTH(2), .TERMINAL(`OSD_LF_EDGES)) u_lf_cnt ( // RULE16
        .clk   (clk),
        .rst_n (rst_n),
        .clear (cnt_dly_clear),
        .tick  (lf_rise),
        .done  (lf_done)
    );

    ////////////////////////////////////////////////////////////////////
    // next state

    logic       is_xtal;
    logic       ext_sel;
    logic       special;
    logic       bus_req;
    logic       wr_ok;
    logic [2:0] wmode;
    logic       wscs;

    always_comb begin
        st_next = st_reg;
        is_xtal = st_reg.ctrl.mode == `OSD_MODE_LOWG || st_reg.ctrl.mode == `OSD_MODE_MEDG
                  || st_reg.ctrl.mode == `OSD_MODE_HIGHG; // RULE14
        ext_sel = !st_reg.ctrl.clk_sel && st_reg.ctrl.mode != `OSD_MODE_INT
                  && st_reg.ctrl.mode != `OSD_MODE_INTIO;
        special = st_reg.ctrl.mode == `OSD_MODE_LOWG && st_reg.ctrl.sec_en
                  && !st_reg.ctrl.clk_sel && st_reg.ext_flag;
        bus_req = avm_req.read || avm_req.write;
        wr_ok   = avm_req.write && !st_reg.waitrequest;
        wmode   = avm_req.writedata[`OSD_CTRL_MODE_MSB:`OSD_CTRL_MODE_LSB];
        wscs    = avm_req.writedata[`OSD_CTRL_CSEL_BIT];
        st_next.osc_prev = oscillator_input_pin;
        st_next.lf_prev  = low_freq_internal_osc;

        // bus: one wait cycle, then the answer for one cycle
        if (bus_req && st_reg.waitrequest) begin
            st_next.waitrequest = 1'b0;
            case (avm_req.address)
                `OSD_ADDR_CTRL: begin
                    st_next.readdata = 32'h0;
                    st_next.readdata[`OSD_CTRL_MODE_MSB:`OSD_CTRL_MODE_LSB] = st_reg.ctrl.mode;
                    st_next.readdata[`OSD_CTRL_SECEN_BIT] = st_reg.ctrl.sec_en;
                    st_next.readdata[`OSD_CTRL_CSEL_BIT]  = st_reg.ctrl.clk_sel;
                    st_next.readdata[`OSD_CTRL_WDTEN_BIT] = st_reg.ctrl.wdt_en;
                end
                `OSD_ADDR_TRIM: st_next.readdata = {27'h0, st_reg.trim};
                `OSD_ADDR_STATUS: begin
                    st_next.readdata = 32'h0;
                    st_next.readdata[`OSD_STAT_EXT_BIT]  = st_reg.ext_flag; // RULE15
                    st_next.readdata[`OSD_STAT_HOLD_BIT] = st_reg.cpu_hold;
                    st_next.readdata[`OSD_STAT_WDTH_BIT] = st_reg.wdt_reset;
                end
                default: st_next.readdata = 32'h0;
            endcase
        end else begin
            st_next.waitrequest = 1'b1;
        end

        // trim takes effect on the oscillator gradually, outside this block
        if (wr_ok && avm_req.address == `OSD_ADDR_TRIM) begin
            st_next.trim = avm_req.writedata[`OSD_TRIM_MSB:0];
        end

        case (st_reg.state)
            osd_pkg::OSD_ST_PWRUP: begin
                if (!power_up_delay_timer_enable || power_up_delay_timer_expired) begin // RULE1
                    st_next.ext_flag = 1'b0;
                    if (ext_sel && is_xtal) begin
                        st_next.state = osd_pkg::OSD_ST_XTAL; // RULE1
                    end else begin
                        st_next.state = osd_pkg::OSD_ST_DELAY; // RULE5 RULE7 RULE8
                    end
                end
            end
            osd_pkg::OSD_ST_XTAL: begin
                if (xtal_done) begin
                    st_next.state    = osd_pkg::OSD_ST_RUN;
                    st_next.ext_flag = ext_sel; // RULE15
                end
            end
            osd_pkg::OSD_ST_DELAY: begin
                if (dly_done && lf_done) begin // RULE16
                    st_next.state    = osd_pkg::OSD_ST_RUN;
                    st_next.ext_flag = ext_sel; // RULE15
                end
            end
            osd_pkg::OSD_ST_RUN: begin
                if (wr_ok && avm_req.address == `OSD_ADDR_CTRL) begin
                    st_next.ctrl.mode   = wmode;
                    st_next.ctrl.sec_en = avm_req.writedata[`OSD_CTRL_SECEN_BIT];
                    st_next.ctrl.clk_sel = wscs;
                    st_next.ctrl.wdt_en = avm_req.writedata[`OSD_CTRL_WDTEN_BIT];
                    if (avm_req.writedata[`OSD_CTRL_SLEEP_BIT]) begin
                        st_next.state    = osd_pkg::OSD_ST_SLEEP;
                        // selecting the internal source on the way into sleep drops the flag too
                        st_next.ext_flag = st_reg.ext_flag && !wscs; // RULE15
                    end else if (wscs) begin
                        st_next.ext_flag = 1'b0; // RULE15
                    end else if (st_reg.ctrl.clk_sel || wmode != st_reg.ctrl.mode) begin
                        // leaving the internal source, or changing the mode code with it deselected
                        st_next.ext_flag = 1'b0;
                        if (wmode == `OSD_MODE_LOWG || wmode == `OSD_MODE_MEDG || wmode == `OSD_MODE_HIGHG) begin
                            st_next.state = osd_pkg::OSD_ST_XTAL; // RULE6
                        end else begin
                            st_next.state = osd_pkg::OSD_ST_DELAY; // RULE7
                        end
                    end
                end
            end
            osd_pkg::OSD_ST_SLEEP: begin
                if (wake_event) begin
                    if (ext_sel && is_xtal && !special) begin
                        st_next.state    = osd_pkg::OSD_ST_XTAL; // RULE1
                        st_next.ext_flag = 1'b0;
                    end else begin
                        st_next.state = osd_pkg::OSD_ST_DELAY; // RULE3 RULE5
                    end
                end
            end
            default: st_next.state = osd_pkg::OSD_ST_PWRUP;
        endcase

        st_next.cpu_hold  = st_next.state != osd_pkg::OSD_ST_RUN; // RULE2
        st_next.wdt_reset = st_next.state == osd_pkg::OSD_ST_XTAL; // RULE4
        st_next.wdt_run   = st_next.ctrl.wdt_en && st_next.state != osd_pkg::OSD_ST_XTAL
                            && st_next.state != osd_pkg::OSD_ST_PWRUP; // RULE4
        case (st_next.ctrl.mode)
            `OSD_MODE_LOWG:  st_next.gain = osd_pkg::OSD_GAIN_LOW; // RULE11
            `OSD_MODE_MEDG:  st_next.gain = osd_pkg::OSD_GAIN_MED; // RULE11
            `OSD_MODE_HIGHG: st_next.gain = osd_pkg::OSD_GAIN_HIGH; // RULE11
            default:         st_next.gain = osd_pkg::OSD_GAIN_OFF;
        endcase
        st_next.pa6_gpio = st_next.ctrl.mode == `OSD_MODE_EXTC || st_next.ctrl.mode == `OSD_MODE_RCAP_IO
                           || st_next.ctrl.mode == `OSD_MODE_INTIO; // RULE10
        st_next.osc_sleep_run = st_next.ctrl.mode == `OSD_MODE_LOWG && st_next.ctrl.sec_en; // RULE12
    end

    ////////////////////////////////////////////////////////////////////
    // state register; plain edge-triggered storage keeps all state when clk stops

    always_ff @(posedge clk or negedge rst_n) begin // RULE9
        if (!rst_n) begin
            st_reg             <= '0;
            st_reg.state       <= osd_pkg::OSD_ST_PWRUP;
            st_reg.ctrl.mode   <= `OSD_MODE_RST;
            st_reg.trim        <= `OSD_TRIM_RST;
            st_reg.waitrequest <= 1'b1;
            st_reg.cpu_hold    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avm_readdata               = st_reg.readdata;
    assign avm_waitrequest            = st_reg.waitrequest;
    assign cpu_hold                   = st_reg.cpu_hold;
    assign watchdog_counter_reset     = st_reg.wdt_reset;
    assign watchdog_counter_run       = st_reg.wdt_run;
    assign amp_gain                   = st_reg.gain;
    assign port_a_bit6_pin_gpio       = st_reg.pa6_gpio;
    assign shared_osc_run_in_sleep    = st_reg.osc_sleep_run;
    assign external_clock_active_flag = st_reg.ext_flag;
    assign trim_value                 = st_reg.trim;

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking a_clk @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_xtal_leave;
        st_reg.state == osd_pkg::OSD_ST_XTAL ##1 st_reg.state == osd_pkg::OSD_ST_RUN;
    endsequence

    sequence s_dly_leave;
        st_reg.state == osd_pkg::OSD_ST_DELAY ##1 st_reg.state == osd_pkg::OSD_ST_RUN;
    endsequence

    sequence s_ctrl_write_xtal;
        st_reg.state == osd_pkg::OSD_ST_RUN && wr_ok && avm_req.address == `OSD_ADDR_CTRL
        && !wscs && !avm_req.writedata[`OSD_CTRL_SLEEP_BIT] && st_reg.ctrl.clk_sel
        && (wmode == `OSD_MODE_LOWG || wmode == `OSD_MODE_MEDG || wmode == `OSD_MODE_HIGHG);
    endsequence

    a_xtal_full_count: assert property (s_xtal_leave |-> $past(xtal_done)) // RULE1
        else $error("crystal count left early");
    a_hold_not_run: assert property (st_reg.state != osd_pkg::OSD_ST_RUN |-> cpu_hold) // RULE2
        else $error("execution not held");
    a_special_skip: assert property (st_reg.state == osd_pkg::OSD_ST_SLEEP && wake_event && special // RULE3
        |=> st_reg.state == osd_pkg::OSD_ST_DELAY)
        else $error("shared oscillator wake counted");
    a_wdt_held: assert property (st_reg.state == osd_pkg::OSD_ST_XTAL |-> watchdog_counter_reset // RULE4
        && !watchdog_counter_run)
        else $error("watchdog not held");
    a_delay_length: assert property (s_dly_leave |-> $past(dly_done) && $past(lf_done)) // RULE5
        else $error("fixed delay too short");
    a_switch_count: assert property (s_ctrl_write_xtal |=> st_reg.state == osd_pkg::OSD_ST_XTAL) // RULE6
        else $error("switch to crystal without count");
    a_extclk_no_count: assert property (st_reg.ctrl.mode == `OSD_MODE_EXTC // RULE8
        |-> st_reg.state != osd_pkg::OSD_ST_XTAL)
        else $error("count in external clock mode");
    a_extclk_pin_free: assert property (st_reg.ctrl.mode == `OSD_MODE_EXTC |-> port_a_bit6_pin_gpio) // RULE10
        else $error("port A bit 6 not released");
    a_gain_map: assert property (st_reg.ctrl.mode == `OSD_MODE_MEDG |-> amp_gain == osd_pkg::OSD_GAIN_MED // RULE11
        && !shared_osc_run_in_sleep)
        else $error("gain does not follow mode");
    a_shared_osc: assert property (st_reg.ctrl.mode == `OSD_MODE_LOWG && st_reg.ctrl.sec_en // RULE12
        |-> shared_osc_run_in_sleep && amp_gain == osd_pkg::OSD_GAIN_LOW)
        else $error("shared oscillator stops in sleep");
    a_flag_internal: assert property (st_reg.ctrl.clk_sel |-> !external_clock_active_flag) // RULE15
        else $error("flag set on internal clock");
    a_bus_answer: assert property (bus_req && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
        else $error("bus answer not one cycle");

endmodule

// ### testbench/osd_osc_model.sv
// Purpose: crystal and low-frequency oscillator stand-ins
// Assumes: levels sampled by the block on clk
// Notes: crystal gives one rising edge per two clk cycles while run is high
`timescale 1ns/10ps
module osd_osc_model #(
    parameter int LF_HALF = 300
) (
    input  wire logic clk,
    input  wire logic run,
    output logic      osc,
    output logic      lf_osc
);
    int lf_cnt;

    initial begin
        osc = 1'b0;
        lf_osc = 1'b0;
        lf_cnt = 0;
    end

    // a stopped source leaves its pin at the last level, as a halted clock does
    always @(posedge clk) begin
        if (run) begin
            osc <= ~osc;
        end
        lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
        if (lf_cnt == LF_HALF - 1) begin
            lf_osc <= ~lf_osc;
        end
    end
endmodule

// ### testbench/osd_startup_ctrl_test.sv
// Purpose: self-checking bench of the start-up delay control
// Assumes: 40 MHz clk, Avalon-MM slave answering through waitrequest
// Notes: rows hold {gain, pin freed, crystal count} per mode code
`timescale 1ns/10ps
`include "osd_consts.svh"
module osd_startup_ctrl_test;
    localparam logic [7:0][3:0] EXP = {4'h2, 4'h0, 4'h2, 4'h0, 4'h2, 4'hd, 4'h9, 4'h5};
    localparam int              FIX = `OSD_FIXED_DELAY_CYC;
    logic                  clk, resetn, osc_run, osc, lf_osc, power_up_delay_timer_en, power_up_delay_timer_done, wake;
    logic                  wait_req, hold, wdt_rst, wdt_run, gpio6, shared_run, ext_flag, saw, f0;
    logic [1:0]            gain;
    logic [2:0]            m;
    logic [4:0]            trim;
    logic [31:0]           rdata, q;
    osd_pkg::osd_avm_req_t req;
    int                    error_cnt, num_checks, cyc;

    osd_startup_ctrl dut_u (.clk(clk), .resetn(resetn), .avm_req(req), .avm_readdata(rdata),
        .avm_waitrequest(wait_req), .oscillator_input_pin(osc), .low_freq_internal_osc(lf_osc),
        .power_up_delay_timer_enable(power_up_delay_timer_en), .power_up_delay_timer_expired(power_up_delay_timer_done),
        .wake_event(wake), .cpu_hold(hold), .watchdog_counter_reset(wdt_rst),
        .watchdog_counter_run(wdt_run), .amp_gain(gain), .port_a_bit6_pin_gpio(gpio6),
        .shared_osc_run_in_sleep(shared_run), .external_clock_active_flag(ext_flag),
        .trim_value(trim));

    osd_osc_model osc_u (.clk(clk), .run(osc_run), .osc(osc), .lf_osc(lf_osc));

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 64);
        if (wait_req !== 1'b0) begin
            chk(wait_req, 0);
            complete_run();
        end
        r = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    // waits for hold to rise, then counts held cycles until release
    task automatic wait_run(output int c, output logic r, output logic f);
        int n;
        n = 0;
        c = 0;
        r = 1'b0;
        while (hold !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (hold !== 1'b1) begin
            chk(hold, 1);
            complete_run();
        end
        f = ext_flag;
        while (hold !== 1'b0 && c < 5000) begin
            @(posedge clk);
            c++;
            if (wdt_rst === 1'b1) begin
                r = 1'b1;
                chk(wdt_run, 0);
            end
        end
        if (hold !== 1'b0) begin
            chk(hold, 0);
            complete_run();
        end
    endtask

    task automatic nap(input logic [31:0] d);
        bus(1'b1, `OSD_ADDR_CTRL, d, q);
        repeat (30) @(posedge clk);
        chk(hold, 1);
        chk(shared_run, d[4]);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        wait_run(cyc, saw, f0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        osc_run = 1'b0;
        power_up_delay_timer_en = 1'b1;
        power_up_delay_timer_done = 1'b0;
        wake = 1'b0;
        req = '0;
        error_cnt = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        chk({wait_req, hold, rdata, gain, gpio6, shared_run, ext_flag, wdt_rst, wdt_run, trim},
            {2'b11, 32'h0, 12'h0});
        resetn <= 1'b1;
        repeat (20) @(posedge clk);
        chk({hold, wdt_rst, wdt_run}, 3'b100);
        power_up_delay_timer_done <= 1'b1;
        repeat (3) @(posedge clk);
        osc_run <= 1'b1;
        repeat (2045) @(posedge clk);
        osc_run <= 1'b0;
        repeat (40) @(posedge clk);
        chk({hold, wdt_rst, gain}, {2'b11, osd_pkg::OSD_GAIN_LOW});
        osc_run <= 1'b1;
        wait_run(cyc, saw, f0);
        chk(cyc < 8, 1);
        chk({ext_flag, wdt_rst}, 2'b10);
        for (int i = 1; i <= 8; i++) begin
            m = 3'(i);
            bus(1'b1, `OSD_ADDR_CTRL, {24'h0, 8'h40 | 8'(m)}, q);
            wait_run(cyc, saw, f0);
            chk(f0, 0);
            chk(saw, EXP[m][0]);
            chk(cyc >= (EXP[m][0] ? 2046 : FIX), 1);
            chk({gain, gpio6, shared_run, wdt_run}, {EXP[m][3:1], 2'b01});
            if (EXP[m][0]) chk(ext_flag, 1);
            bus(1'b0, `OSD_ADDR_CTRL, 32'h0, q);
            chk(q, {24'h0, 8'h40 | 8'(m)});
        end
        bus(1'b1, `OSD_ADDR_CTRL, 32'h50, q);
        nap(32'hd0);
        chk(saw, 0);
        chk(cyc >= FIX, 1);
        bus(1'b1, `OSD_ADDR_CTRL, 32'h41, q);
        wait_run(cyc, saw, f0);
        nap(32'hc1);
        chk({saw, cyc >= 2046}, 2'b11);
        bus(1'b1, `OSD_ADDR_CTRL, 32'h61, q);
        repeat (4) @(posedge clk);
        chk({hold, ext_flag}, 2'b00);
        bus(1'b1, `OSD_ADDR_CTRL, 32'h41, q);
        bus(1'b1, `OSD_ADDR_CTRL, 32'h43, q);
        wait_run(cyc, saw, f0);
        chk({saw, ext_flag, gpio6}, 3'b110);
        bus(1'b0, `OSD_ADDR_CTRL, 32'h0, q);
        chk(q, 32'h41);
        bus(1'b1, `OSD_ADDR_TRIM, 32'hffff_fff5, q);
        bus(1'b0, `OSD_ADDR_TRIM, 32'h0, q);
        chk({q, 3'b0, trim}, {32'h15, 8'h15});
        bus(1'b1, `OSD_ADDR_STATUS, 32'hffff_ffff, q);
        bus(1'b0, `OSD_ADDR_STATUS, 32'h0, q);
        chk(q, 32'h1);
        bus(1'b0, 4'hc, 32'h0, q);
        chk(q, 32'h0);
        resetn <= 1'b0;
        power_up_delay_timer_en <= 1'b0;
        @(posedge clk);
        chk({hold, wait_req, trim}, {2'b11, 5'h0});
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        chk({hold, wdt_rst, ext_flag}, 3'b110);
        complete_run();
    end
endmodule
